// file: logic/gppc_defines.vh
/*
  register offsets, reset values and function codes for the
  general purpose pin control block.
  assumes a 16-bit register address from the serial programming interface.
*/
`ifndef GPPC_DEFINES_VH
`define GPPC_DEFINES_VH

`define GPPC_ADDR_W          16
`define GPPC_PIN_DIRECTION   16'h006E
`define GPPC_IN_FUNC_BIT2    16'h006F
`define GPPC_IN_FUNC_BIT1    16'h0070
`define GPPC_IN_FUNC_BIT0    16'h0071
`define GPPC_OUT_FUNC_BIT2   16'h0072
`define GPPC_OUT_FUNC_BIT1   16'h0073
`define GPPC_OUT_FUNC_BIT0   16'h0074
`define GPPC_RESERVED_BYTE   16'h0075
`define GPPC_CONTROL_BYTE    16'h0076
`define GPPC_INPUT_LEVELS    16'h0219

`define GPPC_DIR_RESET       8'h00
`define GPPC_SEL_RESET       8'h00
`define GPPC_CTL_RESET       8'h00
`define GPPC_ZERO_BYTE       8'h00

`define GPPC_FN_PLAIN_INPUT  3'h0
`define GPPC_FN_OUT_ENABLE   3'h1
`define GPPC_FN_REF_SELECT   3'h5

`define GPPC_PIN_FIRST_REF   2
`define GPPC_PIN_SECOND_REF  3

`endif

// file: logic/gppc_pin_ctrl.v
/*
  general purpose pin control: direction, input function select,
  output function select and control bytes, plus the read-only input
  level byte. eight pins.
  assumes a synchronous byte-wide register port from the serial
  programming interface, with pin levels already synchronous to clk_i.
*/
// How it works
// R1: the levels of pins used as plain inputs read back in the status byte at 0x219.
// R2: each pin has a direction bit, 0 input and 1 output, all clear after reset.
// R3: an input pin with function code 000 copies its level into its status bit.
// R4: pin 2 as an input with code 001 drives the output enable of clock output 2.
// R5: software must not program reserved function codes; their effect is undefined.
// R6: pin 3 as an input with its select code drives bit 0 of the second loop reference select.
// R7: input function codes act only while the pin is an input.
// R8: pins 0, 1 and 3 as inputs with code 001 drive the enables of clock outputs 0, 1 and 3.
// R9: code 101 on pin 3 selects the second loop reference select bit 0 function.
// R10: code 101 on pin 2 makes the pin bit 0 of the first loop reference select.
// R11: each pin's code takes one bit from each of three select bytes at its pin position.
`timescale 1ns/1ps
`default_nettype none
`include "gppc_defines.vh"

module gppc_pin_ctrl
(
  // clock and reset
  input  wire                     clk_i,
  input  wire                     rst_b_i,
  // register port
  input  wire                     reg_wr_i,
  input  wire                     reg_rd_i,
  input  wire [`GPPC_ADDR_W-1:0]  reg_addr_i,
  input  wire [7:0]               reg_wdata_i,
  output reg  [7:0]               reg_rdata_o,
  output reg                      reg_hit_o,
  // pins
  input  wire [7:0]               pin_level_i,
  output wire [7:0]               pin_dir_o,
  output wire [7:0]               output_function_bit2_o,
  output wire [7:0]               output_function_bit1_o,
  output wire [7:0]               output_function_bit0_o,
  output wire [7:0]               pin_control_byte_o,
  // functions driven from pins
  output reg  [3:0]               clock_output_enable_o,
  output reg  [3:0]               clock_output_enable_sel_o,
  output reg                      first_loop_manual_ref_select_o,
  output reg                      first_loop_ref_sel_active_o,
  output reg                      second_loop_manual_ref_select_o,
  output reg                      second_loop_ref_sel_active_o
);

  reg  [7:0] pin_direction;
  reg  [7:0] input_function_bit2;
  reg  [7:0] input_function_bit1;
  reg  [7:0] input_function_bit0;
  reg  [7:0] output_function_bit2;
  reg  [7:0] output_function_bit1;
  reg  [7:0] output_function_bit0;
  reg  [7:0] pin_control_byte;
  reg  [7:0] pin_input_levels;
  reg  [7:0] next_rdata;
  reg        next_hit;

  wire [7:0] fn_plain;
  wire [7:0] fn_oe;
  wire [7:0] fn_ref;

  // one decoder per pin
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : gen_pin
      gppc_pin_func u_func
      (
        .is_output_i   (pin_direction[g]),
        .sel2_i        (input_function_bit2[g]),
        .sel1_i        (input_function_bit1[g]),
        .sel0_i        (input_function_bit0[g]),
        .plain_input_o (fn_plain[g]),
        .out_enable_o  (fn_oe[g]),
        .ref_select_o  (fn_ref[g])
      );
    end
  endgenerate

  assign pin_dir_o              = pin_direction;
  assign output_function_bit2_o = output_function_bit2;
  assign output_function_bit1_o = output_function_bit1;
  assign output_function_bit0_o = output_function_bit0;
  assign pin_control_byte_o     = pin_control_byte;

  // reserved codes get no function; the pin simply does nothing
  // select bytes reset to zero so every pin starts as a plain input
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pin_direction        <= `GPPC_DIR_RESET; // R2
      input_function_bit2  <= `GPPC_SEL_RESET;
      input_function_bit1  <= `GPPC_SEL_RESET;
      input_function_bit0  <= `GPPC_SEL_RESET;
      output_function_bit2 <= `GPPC_SEL_RESET;
      output_function_bit1 <= `GPPC_SEL_RESET;
      output_function_bit0 <= `GPPC_SEL_RESET;
      pin_control_byte     <= `GPPC_CTL_RESET;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == `GPPC_PIN_DIRECTION)
        pin_direction <= reg_wdata_i; // R2
      else if (reg_addr_i == `GPPC_IN_FUNC_BIT2)
        input_function_bit2 <= reg_wdata_i; // R11
      else if (reg_addr_i == `GPPC_IN_FUNC_BIT1)
        input_function_bit1 <= reg_wdata_i; // R11
      else if (reg_addr_i == `GPPC_IN_FUNC_BIT0)
        input_function_bit0 <= reg_wdata_i; // R11
      else if (reg_addr_i == `GPPC_OUT_FUNC_BIT2)
        output_function_bit2 <= reg_wdata_i;
      else if (reg_addr_i == `GPPC_OUT_FUNC_BIT1)
        output_function_bit1 <= reg_wdata_i;
      else if (reg_addr_i == `GPPC_OUT_FUNC_BIT0)
        output_function_bit0 <= reg_wdata_i;
      else if (reg_addr_i == `GPPC_CONTROL_BYTE)
        pin_control_byte <= reg_wdata_i;
    end
  end

  // pin levels registered once; bits of pins not used as plain inputs read 0
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pin_input_levels                <= `GPPC_ZERO_BYTE;
      clock_output_enable_o           <= 4'h0;
      clock_output_enable_sel_o       <= 4'h0;
      first_loop_manual_ref_select_o  <= 1'b0;
      first_loop_ref_sel_active_o     <= 1'b0;
      second_loop_manual_ref_select_o <= 1'b0;
      second_loop_ref_sel_active_o    <= 1'b0;
    end
    else
    begin
      pin_input_levels                <= pin_level_i & fn_plain; // R1 R3
      clock_output_enable_sel_o       <= fn_oe[3:0]; // R4 R8
      clock_output_enable_o           <= pin_level_i[3:0] & fn_oe[3:0]; // R4 R8
      first_loop_ref_sel_active_o     <= fn_ref[`GPPC_PIN_FIRST_REF]; // R10
      first_loop_manual_ref_select_o  <= pin_level_i[`GPPC_PIN_FIRST_REF] &
                                         fn_ref[`GPPC_PIN_FIRST_REF]; // R10
      second_loop_ref_sel_active_o    <= fn_ref[`GPPC_PIN_SECOND_REF]; // R6 R9
      second_loop_manual_ref_select_o <= pin_level_i[`GPPC_PIN_SECOND_REF] &
                                         fn_ref[`GPPC_PIN_SECOND_REF]; // R6 R9
    end
  end

  // read decode; reserved byte reads zero
  always @*
  begin
    next_rdata = `GPPC_ZERO_BYTE;
    next_hit   = 1'b1;
    if (reg_addr_i == `GPPC_PIN_DIRECTION)
      next_rdata = pin_direction;
    else if (reg_addr_i == `GPPC_IN_FUNC_BIT2)
      next_rdata = input_function_bit2;
    else if (reg_addr_i == `GPPC_IN_FUNC_BIT1)
      next_rdata = input_function_bit1;
    else if (reg_addr_i == `GPPC_IN_FUNC_BIT0)
      next_rdata = input_function_bit0;
    else if (reg_addr_i == `GPPC_OUT_FUNC_BIT2)
      next_rdata = output_function_bit2;
    else if (reg_addr_i == `GPPC_OUT_FUNC_BIT1)
      next_rdata = output_function_bit1;
    else if (reg_addr_i == `GPPC_OUT_FUNC_BIT0)
      next_rdata = output_function_bit0;
    else if (reg_addr_i == `GPPC_RESERVED_BYTE)
      next_rdata = `GPPC_ZERO_BYTE;
    else if (reg_addr_i == `GPPC_CONTROL_BYTE)
      next_rdata = pin_control_byte;
    else if (reg_addr_i == `GPPC_INPUT_LEVELS)
      next_rdata = pin_input_levels; // R1
    else
      next_hit = 1'b0;
  end

  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      reg_rdata_o <= `GPPC_ZERO_BYTE;
      reg_hit_o   <= 1'b0;
    end
    else if (reg_rd_i)
    begin
      reg_rdata_o <= next_rdata;
      reg_hit_o   <= next_hit;
    end
  end

endmodule // gppc_pin_ctrl

`default_nettype wire

// file: logic/gppc_pin_func.v
/*
  per-pin input function decode: assembles the three-bit input function
  code of one pin and reports which function is active.
  assumes the direction and select bytes come straight from registers.
*/
`timescale 1ns/1ps
`default_nettype none
`include "gppc_defines.vh"

module gppc_pin_func
(
  // configuration of this pin
  input  wire       is_output_i,
  input  wire       sel2_i,
  input  wire       sel1_i,
  input  wire       sel0_i,
  // decoded functions
  output wire       plain_input_o,
  output wire       out_enable_o,
  output wire       ref_select_o
);

  wire [2:0] input_function_code;

  assign input_function_code = {sel2_i, sel1_i, sel0_i}; // R11

  // function codes only act while the pin is an input
  assign plain_input_o = ~is_output_i &&
                         (input_function_code == `GPPC_FN_PLAIN_INPUT); // R7
  assign out_enable_o  = ~is_output_i &&
                         (input_function_code == `GPPC_FN_OUT_ENABLE); // R7
  assign ref_select_o  = ~is_output_i &&
                         (input_function_code == `GPPC_FN_REF_SELECT); // R7

endmodule // gppc_pin_func

`default_nettype wire

// file: tb/gppc_board_model.sv
/* board logic on the eight pins. assumes the bench names the wanted levels. */
`timescale 1ns/1ps
`default_nettype none
module gppc_board_model
(
  // clock, wanted levels, device direction
  input  wire logic       clk_i,
  input  wire logic [7:0] drive_i,
  input  wire logic [7:0] dir_i,
  // pins
  output var  logic [7:0] level_o
);
  initial level_o = 8'h00;
  // a pin the device owns is released here and wanders, so no stale level passes
  always @(negedge clk_i) level_o <= (dir_i & ~level_o) | (~dir_i & drive_i);
endmodule // gppc_board_model
`default_nettype wire

// file: tb/gppc_pin_ctrl_sva.sv
/* assertions on the pin control ports; bound to every gppc_pin_ctrl instance. */
`timescale 1ns/1ps
`default_nettype none
`include "gppc_defines.vh"
module gppc_pin_ctrl_sva
(
  // clock, reset and register port
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        reg_wr_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [7:0]  reg_wdata_i,
  // pins and functions
  input wire logic [7:0]  pin_level_i,
  input wire logic [7:0]  pin_dir_o,
  input wire logic [3:0]  clock_output_enable_o,
  input wire logic [3:0]  clock_output_enable_sel_o,
  input wire logic        first_loop_manual_ref_select_o,
  input wire logic        first_loop_ref_sel_active_o,
  input wire logic        second_loop_manual_ref_select_o,
  input wire logic        second_loop_ref_sel_active_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  chk_dir_write: assert property (reg_wr_i && reg_addr_i == `GPPC_PIN_DIRECTION
    |=> pin_dir_o == $past(reg_wdata_i)) else $error("direction write lost");
  chk_dir_reset: assert property ($rose(rst_b_i) |-> pin_dir_o == 8'h00)
    else $error("direction not clear after reset");
  chk_oe_level: assert property (((clock_output_enable_o ^ $past(pin_level_i[3:0]))
    & clock_output_enable_sel_o) == 4'h0) else $error("enable not pin level");
  chk_oe_gated: assert property ((clock_output_enable_o & ~clock_output_enable_sel_o)
    == 4'h0) else $error("enable without select");
  chk_oe_input: assert property ((clock_output_enable_sel_o & $past(pin_dir_o[3:0]))
    == 4'h0) else $error("enable select on output pin");
  chk_ref1_level: assert property (first_loop_manual_ref_select_o ==
    (first_loop_ref_sel_active_o && $past(pin_level_i[2]))) else $error("ref1 level");
  chk_ref1_input: assert property (first_loop_ref_sel_active_o |->
    !$past(pin_dir_o[2])) else $error("ref1 on output pin");
  chk_ref2_level: assert property (second_loop_manual_ref_select_o ==
    (second_loop_ref_sel_active_o && $past(pin_level_i[3]))) else $error("ref2 level");
  chk_ref2_input: assert property (second_loop_ref_sel_active_o |->
    !$past(pin_dir_o[3])) else $error("ref2 on output pin");
  cover property (clock_output_enable_sel_o[2] && clock_output_enable_o[2]);
  cover property (first_loop_ref_sel_active_o && first_loop_manual_ref_select_o);
  cover property (second_loop_ref_sel_active_o && second_loop_manual_ref_select_o);
endmodule // gppc_pin_ctrl_sva
bind gppc_pin_ctrl gppc_pin_ctrl_sva chk (.*);
`default_nettype wire

// file: tb/tb.sv
/* bench for the pin control block: a table of pin setups, then register and reset
   cases. assumes the board model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "gppc_defines.vh"
module tb;
  logic        clk_i, rst_b_i, reg_wr_i, reg_rd_i, hit, r1s, r1a, r2s, r2a;
  logic [15:0] reg_addr_i;
  logic [7:0]  reg_wdata_i, drive, pin_level, rdata, dir, fb2, fb1, fb0, ctl;
  logic [3:0]  oe, oes;
  int          fails, samples_checked, i;
  // dir, sel bit2, bit1, bit0, level, status, enables, selects, {ref1,act1,ref2,act2}
  // rows ordered so that no write, even midway through a row, leaves a reserved code
  logic [59:0] rows [7] = '{
    {8'h00, 8'h00, 8'h00, 8'h00, 8'hA5, 8'hA5, 4'h0, 4'h0, 4'h0},
    {8'h00, 8'h00, 8'h00, 8'h0F, 8'h5A, 8'h50, 4'hA, 4'hF, 4'h0},
    {8'h00, 8'h0C, 8'h00, 8'h0C, 8'h0C, 8'h00, 4'h0, 4'h0, 4'hF},
    {8'h0C, 8'h0C, 8'h00, 8'h0C, 8'h0C, 8'h00, 4'h0, 4'h0, 4'h0},
    {8'h00, 8'h04, 8'h00, 8'h0F, 8'hF7, 8'hF0, 4'h3, 4'hB, 4'hC},
    {8'h00, 8'h08, 8'h00, 8'h0C, 8'hF3, 8'hF3, 4'h0, 4'h4, 4'h1},
    {8'hF0, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h0F, 4'h0, 4'h0, 4'h0}};
  // readback values per offset from 0x6E, and a write order that keeps the codes of the input pins legal
  logic [7:0]  vals [9] = '{8'hF2, 8'h0C, 8'hF0, 8'h0F, 8'h65, 8'h76, 8'h87, 8'h98, 8'hA9};
  int          order [9] = '{0, 3, 1, 2, 4, 5, 6, 7, 8};
  gppc_board_model board (.clk_i(clk_i), .drive_i(drive), .dir_i(dir), .level_o(pin_level));
  gppc_pin_ctrl dut
  (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rdata),
    .reg_hit_o(hit), .pin_level_i(pin_level), .pin_dir_o(dir),
    .output_function_bit2_o(fb2), .output_function_bit1_o(fb1),
    .output_function_bit0_o(fb0), .pin_control_byte_o(ctl),
    .clock_output_enable_o(oe), .clock_output_enable_sel_o(oes),
    .first_loop_manual_ref_select_o(r1s), .first_loop_ref_sel_active_o(r1a),
    .second_loop_manual_ref_select_o(r2s), .second_loop_ref_sel_active_o(r2a)
  );
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input logic h);
    @(negedge clk_i);
    reg_rd_i = 1'b1;
    reg_addr_i = a;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    chk("read data", exp, rdata);
    chk("read hit", {7'h00, h}, {7'h00, hit});
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial
  begin
    #20000;
    fails++;
    end_sim;
  end
  initial
  begin
    {rst_b_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, drive} = '0;
    fails = 0;
    samples_checked = 0;
    repeat (10) @(negedge clk_i);
    rst_b_i = 1'b1;
    foreach (rows[r])
    begin
      for (i = 0; i < 4; i++) wr(16'h006E + 16'(i), rows[r][59 - 8 * i -: 8]);
      drive = rows[r][27:20];
      repeat (3) @(negedge clk_i);
      rd(`GPPC_INPUT_LEVELS, rows[r][19:12], 1'b1);
      chk("enables", {rows[r][11:8], rows[r][7:4]}, {oe, oes});
      chk("refs", {4'h0, rows[r][3:0]}, {4'h0, r1s, r1a, r2s, r2a});
    end
    rst_b_i = 1'b0;
    @(negedge clk_i);
    rst_b_i = 1'b1;
    // reset values, then write and read back; the reserved byte must stay zero
    for (i = 0; i < 9; i++) rd(16'h006E + 16'(i), 8'h00, 1'b1);
    for (i = 0; i < 9; i++) wr(16'h006E + 16'(order[i]), vals[order[i]]);
    for (i = 0; i < 9; i++) rd(16'h006E + 16'(i), (i == 7) ? 8'h00 : vals[i], 1'b1);
    chk("direction out", 8'hF2, dir);
    chk("out fn bit2", 8'h65, fb2);
    chk("out fn bit1", 8'h76, fb1);
    chk("out fn bit0", 8'h87, fb0);
    chk("control byte", 8'hA9, ctl);
    // pin 1 also holds code 001 but is an output, so only pin 0 may enable
    chk("enables after readback", 8'h11, {oe, oes});
    chk("refs after readback", 8'h0F, {4'h0, r1s, r1a, r2s, r2a});
    wr(`GPPC_INPUT_LEVELS, 8'hFF);
    rd(`GPPC_INPUT_LEVELS, 8'h00, 1'b1);
    rd(16'h0300, 8'h00, 1'b0);
    end_sim;
  end
endmodule // tb
`default_nettype wire
